// [design/iss_defs.vh]
// Purpose: constants for the interrupt source status block
// Assumes: 8-bit register port, byte addresses as printed
// Notes:   status offsets plus local control register offsets
`ifndef ISS_DEFS_VH
`define ISS_DEFS_VH

// register addresses
`define ISS_ADDR_W        16
`define ISS_STAT_LOW      16'hFE04
`define ISS_STAT_MID      16'hFE05
`define ISS_STAT_HIGH     16'hFE06
`define ISS_EN_LOW        16'hFE08
`define ISS_EN_MID        16'hFE09
`define ISS_EN_HIGH       16'hFE0A
`define ISS_TB_CTRL       16'hFE0B
`define ISS_FLAG_LOW      16'hFE0C
`define ISS_FLAG_MID      16'hFE0D
`define ISS_FLAG_HIGH     16'hFE0E

// widths and reset values
`define ISS_NSRC          16
`define ISS_NFLAG         24
`define ISS_RST8          8'h00
`define ISS_RST_FLAGS     24'h000000
`define ISS_TB_RATE_RST   3'h0
`define ISS_TB_RATE_W     3

// timebase control fields
`define ISS_TB_ACK_BIT    7
`define ISS_TB_RATE_LSB   0
`define ISS_TB_RATE_MSB   2
`define ISS_TB_BASE_W     4
`define ISS_TB_CNT_W      12

// idle line run lengths, in received high bits
`define ISS_IDLE_SHORT    4'hA
`define ISS_IDLE_LONG     4'hB

// flag index map, one per hardware flag
`define F_EXT      0
`define F_LOCK     1
`define F_T1C0     2
`define F_T1C1     3
`define F_T1WRAP   4
`define F_T2C0     5
`define F_T2WRAP   6
`define F_SRX      7
`define F_SOVF     8
`define F_SMODF    9
`define F_STX      10
`define F_AOVR     11
`define F_ANOISE   12
`define F_AFRAME   13
`define F_APAR     14
`define F_ARX      15
`define F_AIDLE    16
`define F_ATX      17
`define F_ADONE    18
`define F_KEY      19
`define F_ADC      20
`define F_TB       21
`define F_SPARE0   22
`define F_SPARE1   23

`endif

// [design/iss_sync.v]
// Purpose: two-flop synchroniser for a bus of asynchronous pins
// Assumes: single clock, clock enable freezes the stages
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module iss_sync #(
  parameter W = 6
) (
  input  wire         mclk_i, // bus clock
  input  wire         rst_i,  // synchronous reset
  input  wire         ce_i,   // clock enable
  input  wire [W-1:0] d_i,    // asynchronous pins
  input  wire [W-1:0] init_i, // value taken at reset
  output reg  [W-1:0] q_o     // synchronised pins
);
  reg [W-1:0] meta;

  // two stages, reset to idle level
  always @(posedge mclk_i) begin
    if (rst_i) begin
      meta <= init_i;
      q_o  <= init_i;
    end else if (ce_i) begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// [design/iss_top.v]
// Purpose: interrupt source flags, gating and status registers
// Assumes: peripherals pass one-cycle event pulses on the bus clock
// Notes:   pins pass a two-flop synchroniser before use
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "iss_defs.vh"

// Notes on behaviour
// - low external request pin latches an external request
// - any lock indication change sets lock change flag, gated by enable
// - first timer wrap to zero sets its wrap flag, gated by enable
// - first timer channel capture or compare sets channel flag, gated
// - second timer wrap to zero sets its wrap flag, gated by enable
// - second timer channel 0 event sets its flag, gated by enable
// - sync port byte into receive register sets receive full flag
// - sync port byte into shift register sets transmit empty flag
// - mode fault sets on slave select misuse while fault enable set
// - sync port overflow sets when unread byte is overtaken
// - async port handing char to shifter sets transmit empty flag
// - transmit done sets only when both empty and no break or idle
// - async receive full sets when char reaches the data register
// - idle line flag sets after ten or eleven high bits
// - receive overrun sets on unread character, feeds serial error
// - noise detection sets noise flag, feeds serial error
// - framing and parity errors set flags, feed serial error
// - low on any of five keypad pins latches keypad request
// - converter requests after each conversion while enabled and select bit clear
// - timebase rollover sets flag; software acks by writing one
// - status bits one to sixteen read one while request pending
// - unassigned status bits always read zero
module iss_top (
  input  wire        mclk_i,        // bus clock, 10 MHz
  input  wire        rst_i,         // synchronous reset, active high
  input  wire        ce_i,          // clock enable, freezes state
  input  wire [15:0] addr_i,        // register address
  input  wire [7:0]  wdata_i,       // register write data
  input  wire        wr_i,          // write strobe
  input  wire        rd_i,          // read strobe
  output reg  [7:0]  rdata_o,       // read data, cycle after strobe
  input  wire        ext_req_n_i,   // external request pin, active low
  input  wire [4:0]  keypad_n_i,    // keypad request pins, active low
  input  wire        lock_i,        // clock generator lock indication
  input  wire        t1_wrap_i,     // first timer wrapped to zero
  input  wire [1:0]  t1_chan_i,     // first timer channel events
  input  wire        t2_wrap_i,     // second timer wrapped to zero
  input  wire        t2_chan0_i,    // second timer channel 0 event
  input  wire        s_rx_load_i,   // sync byte moved to receive reg
  input  wire        s_tx_load_i,   // sync byte moved to shifter
  input  wire        s_unread_i,    // sync receive byte not yet read
  input  wire        s_master_i,    // sync port in master mode
  input  wire        s_busy_i,      // sync transfer in progress
  input  wire        mode_fault_enable_i, // mode fault detect enable
  input  wire        a_tx_load_i,   // async char handed to shifter
  input  wire        a_tx_idle_i,   // async shifter and data reg empty
  input  wire        a_brk_idle_i,  // async break or idle being sent
  input  wire        a_rx_load_i,   // async char into data register
  input  wire        a_unread_i,    // async data register not read
  input  wire        a_rx_bit_i,    // async receive bit strobe
  input  wire        a_rx_val_i,    // async received bit value
  input  wire        a_idle_len_i,  // idle length: 0 ten, 1 eleven
  input  wire        a_noise_i,     // noise seen on a received bit
  input  wire        a_stop_bit_i,  // strobe: stop bit sampled
  input  wire        a_par_bad_i,   // parity mismatch on a character
  input  wire        adc_done_i,    // conversion completed
  input  wire        conv_sel_i,    // converter service select bit
  input  wire [23:0] flag_clr_i,    // peripheral flag clear pulses
  output wire        cpu_irq_o,     // any gated request to the CPU
  output reg  [15:0] pending_o      // per-source gated requests
);

  // flag-to-enable-index rows for the sixteen status bits
  function [`ISS_NFLAG-1:0] src_mask;
    input [4:0] src;
    begin
      src_mask = `ISS_RST_FLAGS;
      case (src)
        5'h01: src_mask[`F_EXT]    = 1'b1;
        5'h02: src_mask[`F_LOCK]   = 1'b1;
        5'h03: src_mask[`F_T1C0]   = 1'b1;
        5'h04: src_mask[`F_T1C1]   = 1'b1;
        5'h05: src_mask[`F_T1WRAP] = 1'b1;
        5'h06: src_mask[`F_T2C0]   = 1'b1;
        5'h08: src_mask[`F_T2WRAP] = 1'b1;
        5'h09: begin
          src_mask[`F_SRX]   = 1'b1;
          src_mask[`F_SOVF]  = 1'b1;
          src_mask[`F_SMODF] = 1'b1;
        end
        5'h0A: src_mask[`F_STX]    = 1'b1;
        5'h0B: begin
          src_mask[`F_AOVR]   = 1'b1;
          src_mask[`F_ANOISE] = 1'b1;
          src_mask[`F_AFRAME] = 1'b1;
          src_mask[`F_APAR]   = 1'b1;
        end
        5'h0C: begin
          src_mask[`F_ARX]   = 1'b1;
          src_mask[`F_AIDLE] = 1'b1;
        end
        5'h0D: begin
          src_mask[`F_ATX]   = 1'b1;
          src_mask[`F_ADONE] = 1'b1;
        end
        5'h0E: src_mask[`F_KEY]    = 1'b1;
        5'h0F: src_mask[`F_ADC]    = 1'b1;
        5'h10: src_mask[`F_TB]     = 1'b1;
        default: src_mask = `ISS_RST_FLAGS;
      endcase
    end
  endfunction

  reg  [`ISS_NFLAG-1:0]     flag;
  reg  [`ISS_NFLAG-1:0]     irq_en;
  reg  [`ISS_NFLAG-1:0]     set_ev;
  wire [`ISS_NFLAG-1:0]     gated;
  reg  [`ISS_TB_RATE_W-1:0] tb_rate;
  reg  [`ISS_TB_CNT_W-1:0]  tb_cnt;
  reg  [`ISS_TB_CNT_W-1:0]  next_tb_cnt;
  reg                       lock_q;
  reg                       ss_q;
  reg                       busy_q;
  reg  [3:0]                idle_cnt;
  reg  [3:0]                idle_need;
  wire [5:0]                pins_s;
  wire                      ext_s;
  wire [4:0]                key_s;
  wire                      ss_s;
  wire                      tb_roll;
  wire                      tb_ack;
  wire                      idle_hit;
  wire [15:0]               pend;

  // pins from outside: keypad, external request
  iss_sync #(
    .W(6)
  ) u_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .d_i    ({keypad_n_i, ext_req_n_i}),
    .init_i (6'h3F),
    .q_o    (pins_s)
  );
  assign ext_s = pins_s[0];
  assign key_s = pins_s[5:1];

  // lock indication comes in on its own one-bit synchroniser into ss_s
  iss_sync #(
    .W(1)
  ) u_sync_lock (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .d_i    (lock_i),
    .init_i (1'h0),
    .q_o    (ss_s)
  );

  // timebase chain: prescale then rate-selected rollover
  always @* begin
    next_tb_cnt = tb_cnt + {{(`ISS_TB_CNT_W-1){1'b0}}, 1'b1};
  end
  assign tb_roll = (next_tb_cnt[`ISS_TB_BASE_W + tb_rate] == 1'b0) &&
                   (tb_cnt[`ISS_TB_BASE_W + tb_rate] == 1'b1);
  assign tb_ack  = wr_i && (addr_i == `ISS_TB_CTRL) &&
                   wdata_i[`ISS_TB_ACK_BIT];

  // idle run length of high received bits
  always @* begin
    idle_need = a_idle_len_i ? `ISS_IDLE_LONG : `ISS_IDLE_SHORT;
  end
  assign idle_hit = a_rx_bit_i && a_rx_val_i &&
                    (idle_cnt == idle_need - 4'h1);

  // event detection for every flag
  always @* begin
    set_ev            = `ISS_RST_FLAGS;
    set_ev[`F_EXT]    = ~ext_s;
    set_ev[`F_LOCK]   = ss_s ^ lock_q;
    set_ev[`F_T1C0]   = t1_chan_i[0];
    set_ev[`F_T1C1]   = t1_chan_i[1];
    set_ev[`F_T1WRAP] = t1_wrap_i;
    set_ev[`F_T2C0]   = t2_chan0_i;
    set_ev[`F_T2WRAP] = t2_wrap_i;
    set_ev[`F_SRX]    = s_rx_load_i;
    set_ev[`F_SOVF]   = s_rx_load_i && s_unread_i;
    set_ev[`F_SMODF]  = mode_fault_enable_i &&
                        ((s_master_i && s_busy_i && !busy_q) ||
                         (!s_master_i && ss_q && !s_busy_i));
    set_ev[`F_STX]    = s_tx_load_i;
    set_ev[`F_AOVR]   = a_rx_load_i && a_unread_i;
    set_ev[`F_ANOISE] = a_noise_i;
    set_ev[`F_AFRAME] = a_stop_bit_i && !a_rx_val_i;
    set_ev[`F_APAR]   = a_par_bad_i;
    set_ev[`F_ARX]    = a_rx_load_i;
    set_ev[`F_AIDLE]  = idle_hit;
    set_ev[`F_ATX]    = a_tx_load_i;
    set_ev[`F_ADONE]  = a_tx_idle_i && !a_brk_idle_i;
    set_ev[`F_KEY]    = ~(&key_s);
    set_ev[`F_ADC]    = adc_done_i;
    set_ev[`F_TB]     = tb_roll;
  end

  // sticky flags: set wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < `ISS_NFLAG; gi = gi + 1) begin : g_flag
      always @(posedge mclk_i) begin
        if (rst_i) begin
          flag[gi] <= 1'b0;
        end else if (ce_i) begin
          if (set_ev[gi]) begin
            flag[gi] <= 1'b1;
          end else if (flag_clr_i[gi] ||
                       ((gi == `F_TB) && tb_ack)) begin
            flag[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // converter request only with select bit clear
  assign gated = flag & irq_en &
                 ~({{(`ISS_NFLAG-1){1'b0}}, conv_sel_i} << `F_ADC);

  // per-source pending from gated flags
  generate
    for (gi = 1; gi <= `ISS_NSRC; gi = gi + 1) begin : g_pend
      // source number cut to the function's five-bit argument
      localparam [4:0] SRC = gi[4:0];
      assign pend[gi-1] = |(gated & src_mask(SRC));
    end
  endgenerate
  assign cpu_irq_o = |pending_o;

  // edge history, timebase chain, idle counter, pending register
  always @(posedge mclk_i) begin
    if (rst_i) begin
      lock_q    <= 1'b0;
      ss_q      <= 1'b0;
      busy_q    <= 1'b0;
      tb_cnt    <= {`ISS_TB_CNT_W{1'b0}};
      idle_cnt  <= 4'h0;
      pending_o <= 16'h0000;
    end else if (ce_i) begin
      lock_q    <= ss_s;
      ss_q      <= s_busy_i;
      busy_q    <= s_busy_i;
      tb_cnt    <= next_tb_cnt;
      pending_o <= pend;
      if (a_rx_bit_i) begin
        idle_cnt <= (a_rx_val_i && !idle_hit) ?
                    idle_cnt + 4'h1 : 4'h0;
      end
    end
  end

  // control registers: enables and timebase rate
  always @(posedge mclk_i) begin
    if (rst_i) begin
      irq_en  <= `ISS_RST_FLAGS;
      tb_rate <= `ISS_TB_RATE_RST;
    end else if (ce_i && wr_i) begin
      case (addr_i)
        `ISS_EN_LOW:  irq_en[7:0]   <= wdata_i;
        `ISS_EN_MID:  irq_en[15:8]  <= wdata_i;
        `ISS_EN_HIGH: irq_en[23:16] <= wdata_i;
        `ISS_TB_CTRL: tb_rate <=
          wdata_i[`ISS_TB_RATE_MSB:`ISS_TB_RATE_LSB];
        default: irq_en <= irq_en; // status writes ignored
      endcase
    end
  end

  // read port, data one cycle after the strobe
  always @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= `ISS_RST8;
    end else if (ce_i) begin
      rdata_o <= `ISS_RST8;
      if (rd_i) begin
        case (addr_i)
          `ISS_STAT_LOW:  rdata_o <= {pending_o[5:0], 2'b00};
          `ISS_STAT_MID:  rdata_o <= pending_o[13:6];
          `ISS_STAT_HIGH: rdata_o <= {6'h00, pending_o[15:14]};
          `ISS_EN_LOW:    rdata_o <= irq_en[7:0];
          `ISS_EN_MID:    rdata_o <= irq_en[15:8];
          `ISS_EN_HIGH:   rdata_o <= irq_en[23:16];
          `ISS_TB_CTRL:   rdata_o <= {5'h00, tb_rate};
          `ISS_FLAG_LOW:  rdata_o <= flag[7:0];
          `ISS_FLAG_MID:  rdata_o <= flag[15:8];
          `ISS_FLAG_HIGH: rdata_o <= flag[23:16];
          default:        rdata_o <= `ISS_RST8;
        endcase
      end
    end
  end
endmodule

// [dv/iss_checker.sv]
// Purpose: port-level checks for the interrupt status block
// Assumes: one clock domain, synchronous reset
// Notes:   bound onto iss_top below
`timescale 1ns/1ps
`include "iss_defs.vh"
module iss_checker (
  input wire        mclk_i,     // bus clock
  input wire        rst_i,      // synchronous reset
  input wire        ce_i,       // clock enable
  input wire [15:0] addr_i,     // register address
  input wire        wr_i,       // write strobe
  input wire        rd_i,       // read strobe
  input wire [7:0]  rdata_o,    // read data
  input wire [23:0] flag_clr_i, // flag clear pulses
  input wire        cpu_irq_o,  // cpu request
  input wire [15:0] pending_o   // gated requests
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire rd_ok = rd_i && ce_i;

  rst_clear_a: assert property (disable iff (1'b0)
    rst_i |=> pending_o == 16'h0000 && rdata_o == 8'h00)
    else $error("state not cleared by reset");
  irq_or_a: assert property (cpu_irq_o == (|pending_o))
    else $error("cpu request differs from pending bits");
  rsvd_zero_a: assert property (pending_o[6] == 1'b0)
    else $error("reserved status bit set");
  low_read_a: assert property (rd_ok && addr_i == `ISS_STAT_LOW
    |=> rdata_o == {$past(pending_o[5:0]), 2'h0})
    else $error("low status read wrong");
  mid_read_a: assert property (rd_ok && addr_i == `ISS_STAT_MID
    |=> rdata_o == $past(pending_o[13:6]))
    else $error("mid status read wrong");
  high_read_a: assert property (rd_ok && addr_i == `ISS_STAT_HIGH
    |=> rdata_o == {6'h00, $past(pending_o[15:14])})
    else $error("high status read wrong");
  idle_zero_a: assert property ($past(ce_i && !rd_i)
    |-> rdata_o == 8'h00)
    else $error("read data without a read");
  freeze_a: assert property (!ce_i |=> $stable(pending_o))
    else $error("pending moved while frozen");
  wrap_fall_a: assert property ($fell(pending_o[4])
    |-> $past(flag_clr_i[4], 2) || $past(wr_i, 2))
    else $error("wrap request dropped without cause");
endmodule

bind iss_top iss_checker u_iss_checker (.mclk_i(mclk_i), .rst_i(rst_i),
  .ce_i(ce_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .flag_clr_i(flag_clr_i), .cpu_irq_o(cpu_irq_o),
  .pending_o(pending_o));

// [dv/iss_periph_model.sv]
// Purpose: stand-in for the peripherals feeding the status block
// Assumes: events are one-cycle pulses on the bus clock
// Notes:   the bench calls the tasks; levels rest between calls
`timescale 1ns/1ps
module iss_periph_model (
  input  wire        mclk_i, // bus clock
  output reg  [13:0] ev_o,   // event pulses
  output reg  [16:0] lv_o,   // levels and active-low pins
  output reg  [23:0] clr_o   // flag clear pulses
);
  localparam [16:0] REST = {5'h1F, 12'h209};
  // idle values at time zero
  initial begin
    ev_o = 14'h0000;
    lv_o = REST;
    clr_o = 24'h000000;
  end
  // one-cycle pulse on event line k
  task pulse(input integer k);
    begin
      @(posedge mclk_i) ev_o <= 14'h0001 << k;
      @(posedge mclk_i) ev_o <= 14'h0000;
    end
  endtask
  // set level bit k after the next edge
  task level(input integer k, input v);
    begin
      @(posedge mclk_i) lv_o[k] <= v;
    end
  endtask
  // back to rest, lock level kept
  task quiet;
    begin
      @(posedge mclk_i) lv_o <= REST | (lv_o & 17'h00002);
    end
  endtask
  // clear every flag for one cycle
  task clr;
    begin
      @(posedge mclk_i) clr_o <= 24'hFFFFFF;
      @(posedge mclk_i) clr_o <= 24'h000000;
    end
  endtask
  // raise one source (two for code 11), or a near miss that must not set
  task fire(input integer c);
    integer n;
    begin
      case (c)
        0: level(0, 1'b0);
        1, 26: level(1, ~lv_o[1]);
        2, 3: pulse(c - 1);
        4: pulse(0);
        5: pulse(4);
        6: pulse(3);
        7: pulse(5);
        10: pulse(6);
        12: pulse(10);
        14: pulse(12);
        15: pulse(8);
        17: pulse(7);
        18: level(6, 1'b1);
        19: level(16, 1'b0);
        20: pulse(13);
        28: level(4, 1'b1);
        8, 11: begin
          level(c == 8 ? 2 : 8, 1'b1);
          pulse(c == 8 ? 5 : 8);
        end
        9, 27: begin
          level(5, 1'b1);
          level(3, c == 9);
          level(4, 1'b1);
          level(4, c == 9);
        end
        13: begin
          level(9, 1'b0);
          pulse(11);
        end
        16, 29: begin
          for (n = 0; n < c - 6 - (c == 29) * 14; n = n + 1)
            pulse(9);
        end
        30: begin
          level(7, 1'b1);
          level(6, 1'b1);
        end
        31: begin
          level(11, 1'b1);
          pulse(13);
        end
        default: ;
      endcase
    end
  endtask
endmodule

// [dv/tb_top.sv]
// Purpose: register-level tests of the interrupt status block
// Assumes: 10 MHz bus clock, reads answer one cycle later
// Notes:   sources come from iss_periph_model
`timescale 1ns/1ps
`include "iss_defs.vh"
`define CHK(n, e, g) begin compares = compares + 1; \
  if ((g) !== (e)) begin error_cnt = error_cnt + 1; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top;
  reg         mclk_i  = 1'b0;
  reg         rst_i   = 1'b1;
  reg         ce_i    = 1'b1;
  reg  [15:0] addr_i  = 16'h0000;
  reg  [7:0]  wdata_i = 8'h00;
  reg         wr_i    = 1'b0;
  reg         rd_i    = 1'b0;
  wire [7:0]  rdata_o;
  wire        cpu_irq_o;
  wire [15:0] pending_o;
  wire [13:0] ev;
  wire [16:0] lv;
  wire [23:0] clr;
  integer     error_cnt = 0;
  integer     compares = 0;
  integer     cyc = 0;
  integer     i, t0, t1;
  integer     codes [0:26] = '{0, 1, 26, 2, 3, 4, 5, 6, 7, 8, 9, 27, 28,
    10, 11, 12, 13, 14, 15, 16, 29, 17, 18, 30, 19, 20, 31};
  // clock and cycle count
  always #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc <= cyc + 1;

  iss_periph_model u_iss_periph_model (.mclk_i(mclk_i), .ev_o(ev),
    .lv_o(lv), .clr_o(clr));
  iss_top u_iss_top (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .ext_req_n_i(lv[0]), .keypad_n_i(lv[16:12]),
    .lock_i(lv[1]), .t1_wrap_i(ev[0]), .t1_chan_i(ev[2:1]),
    .t2_wrap_i(ev[3]), .t2_chan0_i(ev[4]), .s_rx_load_i(ev[5]),
    .s_tx_load_i(ev[6]), .s_unread_i(lv[2]), .s_master_i(lv[3]),
    .s_busy_i(lv[4]), .mode_fault_enable_i(lv[5]), .a_tx_load_i(ev[7]),
    .a_tx_idle_i(lv[6]), .a_brk_idle_i(lv[7]), .a_rx_load_i(ev[8]),
    .a_unread_i(lv[8]), .a_rx_bit_i(ev[9]), .a_rx_val_i(lv[9]),
    .a_idle_len_i(lv[10]), .a_noise_i(ev[10]), .a_stop_bit_i(ev[11]),
    .a_par_bad_i(ev[12]), .adc_done_i(ev[13]), .conv_sel_i(lv[11]),
    .flag_clr_i(clr), .cpu_irq_o(cpu_irq_o), .pending_o(pending_o));

  // expected pending word for each source code
  function [15:0] expv(input integer c);
    case (c)
      0, 1, 2, 3, 4, 5: expv = 16'h0001 << c;
      26: expv = 16'h0002;
      6: expv = 16'h0080;
      7, 8, 9, 27: expv = 16'h0100;
      10: expv = 16'h0200;
      11: expv = 16'h0C00;
      12, 13, 14: expv = 16'h0400;
      15, 16: expv = 16'h0800;
      17, 18: expv = 16'h1000;
      19: expv = 16'h2000;
      20: expv = 16'h4000;
      default: expv = 16'h0000;
    endcase
  endfunction
  // one-cycle register write
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
    end
  endtask
  // read, data checked in the following cycle
  task rd(input [15:0] a, input [7:0] e);
    begin
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 `CHK("rdata_o", e, rdata_o)
    end
  endtask
  // all three status registers against a pending word
  task rd_all(input [15:0] e);
    begin
      rd(`ISS_STAT_LOW, {e[5:0], 2'h0});
      rd(`ISS_STAT_MID, e[13:6]);
      rd(`ISS_STAT_HIGH, {6'h00, e[15:14]});
    end
  endtask
  // bounded wait for one pending bit
  task wait_bit(input integer b, input v);
    integer n;
    begin
      #1;
      n = 0;
      while (pending_o[b] !== v && n < 300) begin
        @(posedge mclk_i);
        #1 n = n + 1;
      end
      if (n == 300) begin
        error_cnt = error_cnt + 1;
        close_out;
      end
    end
  endtask
  task close_out;
    begin
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd_all(16'h0000);
    rd(`ISS_EN_LOW, 8'h00);
    u_iss_periph_model.fire(4);
    repeat (4) @(posedge mclk_i);
    rd_all(16'h0000);
    wr(`ISS_EN_LOW, 8'hFF);
    wr(`ISS_STAT_LOW, 8'h00);
    rd_all(16'h0010);
    @(posedge mclk_i);
    ce_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    ce_i <= 1'b1;
    u_iss_periph_model.clr;
    repeat (3) @(posedge mclk_i);
    rd_all(16'h0000);
    $display("test masking done");
    wr(`ISS_EN_MID, 8'hFF);
    wr(`ISS_EN_HIGH, 8'h1F);
    for (i = 0; i < 27; i = i + 1) begin
      u_iss_periph_model.fire(codes[i]);
      repeat (6) @(posedge mclk_i);
      rd_all(expv(codes[i]));
      `CHK("cpu_irq_o", |expv(codes[i]), cpu_irq_o)
      u_iss_periph_model.quiet;
      repeat (4) @(posedge mclk_i);
      u_iss_periph_model.clr;
      repeat (3) @(posedge mclk_i);
      rd_all(16'h0000);
    end
    $display("test sources done");
    wr(`ISS_EN_LOW, 8'h00);
    wr(`ISS_EN_MID, 8'h00);
    wr(`ISS_EN_HIGH, 8'h20);
    wr(`ISS_TB_CTRL, 8'h81);
    t0 = 0;
    for (i = 0; i < 2; i = i + 1) begin
      wait_bit(15, 1'b0);
      wait_bit(15, 1'b1);
      t1 = cyc - t0;
      t0 = cyc;
      wr(`ISS_TB_CTRL, 8'h81);
    end
    `CHK("rollover period", 64, t1)
    $display("test timebase done");
    rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd_all(16'h0000);
    rd(`ISS_EN_HIGH, 8'h00);
    $display("test reset done");
    close_out;
  end
endmodule
